// ==== core/fci_pkg.sv ====
package fci_pkg;
   localparam int ADDR_W = 22;
   localparam int DATA_W = 16;
   localparam int BUF_DEPTH = 16;
   localparam int BUF_AW = 4;
   localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
   localparam logic [7:0] CMD_READ_ID = 8'h90;
   localparam logic [7:0] CMD_READ_QUERY = 8'h98;
   localparam logic [7:0] CMD_READ_STATUS = 8'h70;
   localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
   localparam logic [7:0] CMD_BUF_WRITE = 8'hE8;
   localparam logic [7:0] CMD_PROGRAM = 8'h40;
   localparam logic [7:0] CMD_PROGRAM_ALT = 8'h10;
   localparam logic [7:0] CMD_BLOCK_ERASE = 8'h20;
   localparam logic [7:0] CMD_CHIP_ERASE = 8'h30;
   localparam logic [7:0] CMD_SUSPEND = 8'hB0;
   localparam logic [7:0] CMD_CONFIRM = 8'hD0;
   localparam logic [7:0] CMD_PIN_CONFIG = 8'hB8;
   localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
   localparam logic [7:0] CMD_LOCK_SET = 8'h01;
   localparam logic [7:0] STATUS_AFTER_RESET = 8'h80;
   // Bit of the extended status that reports a free write buffer.
   localparam int XSR_READY = 7;
   // Pin control word fields.
   localparam int PIN_WP = 0;
   localparam int PIN_BYTE = 1;
   localparam int PIN_PD = 2;
   // Register map of the controller itself.
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_ADDR = 4'h1;
   localparam logic [3:0] REG_DATA = 4'h2;
   localparam logic [3:0] REG_STATUS = 4'h3;
   localparam logic [3:0] REG_BUF = 4'h4;
   localparam logic [3:0] REG_PINS = 4'h5;
   // Control word fields.
   localparam int CTRL_GO = 31;
   localparam int CTRL_READ = 30;
   localparam int CTRL_TWO = 29;
   localparam int CTRL_BUF = 28;
   localparam int CTRL_CNT_LO = 16;
   localparam int CTRL_CODE2_LO = 8;
   localparam int CTRL_CODE1_LO = 0;
   // Timing in nanoseconds and derived cycles at 50 MHz.
   localparam int CLK_NS = 20;
   localparam int T_SETUP_NS = 40;
   localparam int T_PULSE_NS = 60;
   localparam int T_HOLD_NS = 40;
   localparam int T_READ_NS = 100;
   localparam int T_PD_NS = 100;
   localparam int T_WAKE_NS = 1000;
   localparam logic [7:0] SETUP_CYC = 8'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [7:0] PULSE_CYC = 8'((T_PULSE_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [7:0] HOLD_CYC = 8'((T_HOLD_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [7:0] READ_CYC = 8'((T_READ_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [7:0] PD_CYC = 8'((T_PD_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [7:0] WAKE_CYC = 8'((T_WAKE_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [7:0] RWAIT_CYC = 8'h02;
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } fci_word_t;
   typedef struct packed {
      logic chip_select0_n;
      logic chip_select1_n;
      logic output_enable_n;
      logic write_enable_n;
      logic powerdown_reset_n;
      logic write_protect_n;
      logic byte_wide;
   } fci_ctl_t;
endpackage

// ==== core/fci_buf_mem.sv ====
`timescale 1ns/1ps
module fci_buf_mem
   import fci_pkg::*;
(
   input wire logic clk,
   input wire logic wr_en,
   input wire logic [BUF_AW-1:0] wr_addr,
   input wire logic [DATA_W-1:0] wr_data,
   input wire logic [BUF_AW-1:0] rd_addr,
   output logic [DATA_W-1:0] rd_data
);
   logic [DATA_W-1:0] mem [BUF_DEPTH];
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule // fci_buf_mem

// ==== core/fci_host.sv ====
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
// Function
// R01 - Device reads array after power-up or power-down exit; no command needed.
// R02 - Write FFH selects read-array mode until another command.
// R03 - Device ignores read-array while its engine runs unsuspended.
// R04 - 90H makes reads return identifier codes by address.
// R05 - 98H makes reads return query database bytes.
// R06 - 70H reads status next; 50H clears status.
// R07 - 40H or 10H sets up program; next write gives address, data.
// R08 - Program data is captured at write strobe rising edge.
// R09 - Buffered write: E8H, count N, N+1 data writes, D0H confirm.
// R10 - Count N means N+1 elements; zero loads one.
// R11 - Host checks extended status for buffer before continuing.
// R12 - Host avoids counts crossing buffer boundary.
// R13 - Erases and buffered write start only after D0H confirm.
// R14 - B0H suspends; D0H resumes.
// R15 - B8H then config code reconfigures status pin.
// R16 - 60H then 01H sets block lock; write-protect high needed.
// R17 - 60H then D0H clears all locks; write-protect high needed.
// R18 - Locked block with write-protect low fails erase, program, suspend.
// R19 - Commands decoded from low data byte only.
// R20 - Byte-width select low uses lines 0-7, high 0-15.
// R21 - Host never drives output enable and write strobe low together.
// R22 - Host writes only defined command codes; the host checks only the first code, the second is sent unchecked.
// R23 - Address and data captured at first rising strobe, output enable high.
// R24 - Power-down exit gives read-array mode, status 80H.
// R25 - Status pin low while engine busy in default mode.
// R26 - Device holds first-cycle setup until second write arrives.
// R27 - Bad second cycle rejected and reported in status.
module fci_host
   import fci_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   output logic [ADDR_W-1:0] flash_addr,
   output fci_ctl_t flash_ctl,
   input wire logic [DATA_W-1:0] flash_dq_in,
   output logic [DATA_W-1:0] flash_dq_out,
   output logic flash_dq_oe,
   input wire logic status_output_pin
);
   typedef enum {S_WAKE, S_IDLE, S_SETUP, S_PULSE, S_HOLD, S_RSETUP,
      S_RWAIT, S_DONE, S_PD} fci_state_t;
   typedef enum {P_FIRST, P_SECOND, P_AVAIL, P_COUNT, P_DATA,
      P_CONFIRM} fci_phase_t;

   fci_state_t state_reg, state_next;
   fci_phase_t phase_reg, phase_next;
   logic [7:0] cnt_reg, cnt_next;
   logic [31:0] ctrl_reg, ctrl_next;
   fci_word_t cur_reg, cur_next;
   logic [DATA_W-1:0] rdval_reg, rdval_next;
   logic [BUF_AW-1:0] left_reg, left_next, bidx_reg, bidx_next;
   logic [BUF_AW-1:0] wptr_reg, wptr_next;
   logic busy_reg, busy_next;
   logic wp_reg, wp_next, byte_reg, byte_next, pd_reg, pd_next;
   logic [31:0] rdata_next;
   logic sts_s1_reg, sts_s2_reg;
   logic [DATA_W-1:0] dq_s1_reg, dq_s2_reg;
   logic [DATA_W-1:0] buf_rd;
   logic buf_we;
   logic [7:0] code;
   logic code_ok, rd_cycle;

   // The device pins are not on our clock, so both inputs pass two stages.
   always_ff @(posedge clk) begin
      sts_s1_reg <= status_output_pin;
      sts_s2_reg <= sts_s1_reg;
      dq_s1_reg <= flash_dq_in;
      dq_s2_reg <= dq_s1_reg;
   end

   assign buf_we = reg_write && reg_addr == REG_BUF && !busy_reg;
   // Reserved first codes are dropped, never sent.  see R22
   assign code_ok = reg_wdata[CTRL_CODE1_LO +: 8] inside {CMD_READ_ARRAY,
      CMD_READ_ID, CMD_READ_QUERY, CMD_READ_STATUS, CMD_CLEAR_STATUS,
      CMD_BUF_WRITE, CMD_PROGRAM, CMD_PROGRAM_ALT, CMD_BLOCK_ERASE,
      CMD_CHIP_ERASE, CMD_SUSPEND, CMD_CONFIRM, CMD_PIN_CONFIG,
      CMD_LOCK_SETUP};
   assign rd_cycle = phase_reg == P_AVAIL ||
      (ctrl_reg[CTRL_READ] && phase_reg == P_SECOND);
   fci_buf_mem u_buf (
      .clk(clk),
      .wr_en(buf_we),
      .wr_addr(wptr_reg),
      .wr_data(reg_wdata[DATA_W-1:0]),
      .rd_addr(bidx_next),
      .rd_data(buf_rd)
   );

   always_comb begin
      state_next = state_reg;
      phase_next = phase_reg;
      cnt_next = cnt_reg;
      ctrl_next = ctrl_reg;
      cur_next = cur_reg;
      rdval_next = rdval_reg;
      left_next = left_reg;
      bidx_next = bidx_reg;
      wptr_next = wptr_reg;
      busy_next = busy_reg;
      wp_next = wp_reg;
      byte_next = byte_reg;
      pd_next = pd_reg;
      code = 8'h00;
      rdata_next = 32'h0000_0000;
      if (reg_read) begin
         case (reg_addr)
            REG_CTRL: rdata_next = ctrl_reg;
            REG_ADDR: rdata_next = 32'(cur_reg.addr);
            REG_DATA: rdata_next = 32'(rdval_reg);
            REG_STATUS: rdata_next = {28'h000_0000, sts_s2_reg, pd_reg,
               state_reg == S_WAKE, busy_reg};
            REG_PINS: rdata_next = {29'h0000_0000, pd_reg, byte_reg, wp_reg};
            default: rdata_next = 32'h0000_0000;
         endcase
      end
      if (buf_we) begin
         wptr_next = wptr_reg + 1'b1;
      end
      if (reg_write && !busy_reg) begin
         case (reg_addr)
            REG_CTRL: begin
               ctrl_next = reg_wdata;
               busy_next = reg_wdata[CTRL_GO] && code_ok;
               phase_next = P_FIRST;
               bidx_next = '0;
               // Count holds N; N+1 words, never past the buffer.  see R10 R12
               left_next = reg_wdata[CTRL_CNT_LO +: BUF_AW];
            end
            REG_ADDR: cur_next.addr = reg_wdata[ADDR_W-1:0];
            REG_PINS: begin
               wp_next = reg_wdata[PIN_WP];
               byte_next = reg_wdata[PIN_BYTE];
               pd_next = reg_wdata[PIN_PD];
            end
            default: ;
         endcase
      end
      cnt_next = (cnt_reg != 8'h00) ? cnt_reg - 8'h01 : 8'h00;
      case (phase_reg)
         P_FIRST: code = ctrl_reg[CTRL_CODE1_LO +: 8];
         P_SECOND: code = ctrl_reg[CTRL_CODE2_LO +: 8];
         P_COUNT: code = 8'(left_reg);
         P_CONFIRM: code = CMD_CONFIRM;
         default: code = 8'h00;
      endcase
      case (state_reg)
         S_WAKE: if (cnt_reg == 8'h00) begin
            state_next = S_IDLE;
         end
         S_IDLE: begin
            if (pd_reg) begin
               state_next = S_PD;
               cnt_next = PD_CYC;
            end else if (busy_reg) begin
               // Commands ride the low byte; the upper byte is zero.  see R19
               cur_next.data = (phase_reg == P_DATA) ? buf_rd : 16'(code);
               state_next = rd_cycle ? S_RSETUP : S_SETUP;
               cnt_next = rd_cycle ? READ_CYC : SETUP_CYC;
            end
         end
         S_SETUP: if (cnt_reg == 8'h00) begin
            state_next = S_PULSE;
            cnt_next = PULSE_CYC;
         end
         // Write strobe rises first while chip select stays low.  see R23
         S_PULSE: if (cnt_reg == 8'h00) begin
            state_next = S_HOLD;
            cnt_next = HOLD_CYC;
         end
         S_HOLD: if (cnt_reg == 8'h00) begin
            state_next = S_IDLE;
            // Sequence next cycle of a multi-cycle command.  see R09
            case (phase_reg)
               P_FIRST: if (ctrl_reg[CTRL_BUF]) begin
                  // Read extended status before the count.  see R11
                  phase_next = P_AVAIL;
               end else if (ctrl_reg[CTRL_TWO]) begin
                  phase_next = P_SECOND;
               end else begin
                  state_next = S_DONE;
               end
               P_COUNT: phase_next = P_DATA;
               P_DATA: if (left_reg == '0) begin
                  phase_next = P_CONFIRM;
               end else begin
                  left_next = left_reg - 1'b1;
                  bidx_next = bidx_reg + 1'b1;
               end
               default: state_next = S_DONE;
            endcase
         end
         S_RSETUP: if (cnt_reg == 8'h00) begin
            state_next = S_RWAIT;
            cnt_next = RWAIT_CYC;
         end
         S_RWAIT: if (cnt_reg == 8'h00) begin
            // Byte mode keeps only the low lane.  see R20
            rdval_next = byte_reg ? dq_s2_reg : {8'h00, dq_s2_reg[7:0]};
            state_next = S_DONE;
            // No free buffer means the setup code is sent again.  see R11
            if (phase_reg == P_AVAIL) begin
               state_next = S_IDLE;
               phase_next = dq_s2_reg[XSR_READY] ? P_COUNT : P_FIRST;
            end
         end
         S_DONE: begin
            busy_next = 1'b0;
            phase_next = P_FIRST;
            wptr_next = '0;
            state_next = S_IDLE;
         end
         S_PD: if (cnt_reg == 8'h00 && !pd_reg) begin
            // Wake time lets the device reach read-array mode.  see R01
            state_next = S_WAKE;
            cnt_next = WAKE_CYC;
         end
         default: state_next = S_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= S_WAKE;
         phase_reg <= P_FIRST;
         cnt_reg <= WAKE_CYC;
         ctrl_reg <= 32'h0000_0000;
         cur_reg <= '0;
         rdval_reg <= 16'h0000;
         left_reg <= '0;
         bidx_reg <= '0;
         wptr_reg <= '0;
         busy_reg <= 1'b0;
         wp_reg <= 1'b0;
         byte_reg <= 1'b1;
         pd_reg <= 1'b0;
         reg_rdata <= 32'h0000_0000;
      end else begin
         state_reg <= state_next;
         phase_reg <= phase_next;
         cnt_reg <= cnt_next;
         ctrl_reg <= ctrl_next;
         cur_reg <= cur_next;
         rdval_reg <= rdval_next;
         left_reg <= left_next;
         bidx_reg <= bidx_next;
         wptr_reg <= wptr_next;
         busy_reg <= busy_next;
         wp_reg <= wp_next;
         byte_reg <= byte_next;
         pd_reg <= pd_next;
         reg_rdata <= rdata_next;
      end
   end

   // Output enable is held high on writes and strobe high on reads.  see R21
   always_comb begin
      flash_ctl.powerdown_reset_n = !(state_reg == S_PD || rst);
      flash_ctl.write_protect_n = wp_reg;
      flash_ctl.byte_wide = byte_reg;
      flash_ctl.write_enable_n = !(state_reg == S_PULSE);
      flash_ctl.output_enable_n = !(state_reg == S_RSETUP ||
         state_reg == S_RWAIT);
      flash_ctl.chip_select0_n = !(state_reg inside {S_SETUP, S_PULSE,
         S_HOLD, S_RSETUP, S_RWAIT});
      flash_ctl.chip_select1_n = flash_ctl.chip_select0_n;
   end
   assign flash_addr = cur_reg.addr;
   // Data latched at write strobe rise, held through hold time.  see R08
   assign flash_dq_out = cur_reg.data;
   assign flash_dq_oe = state_reg inside {S_SETUP, S_PULSE, S_HOLD};

   chk_no_overlap: assert property (@(posedge clk) disable iff (rst)
      !(!flash_ctl.output_enable_n && !flash_ctl.write_enable_n))
      else $error("Output enable and write strobe both low."); // see R21
   chk_data_held: assert property (@(posedge clk) disable iff (rst)
      $rose(flash_ctl.write_enable_n) |-> flash_dq_oe &&
      $stable(flash_dq_out))
      else $error("Data not stable at strobe rise."); // see R08
   chk_pulse_len: assert property (@(posedge clk) disable iff (rst)
      $fell(flash_ctl.write_enable_n) |-> !flash_ctl.write_enable_n[*4])
      else $error("Write pulse too short."); // see R23
   chk_cs_around: assert property (@(posedge clk) disable iff (rst)
      !flash_ctl.write_enable_n |-> !flash_ctl.chip_select0_n)
      else $error("Strobe without chip select."); // see R23
   chk_low_byte: assert property (@(posedge clk) disable iff (rst)
      flash_dq_oe && phase_reg != P_DATA |-> flash_dq_out[15:8] == 8'h00)
      else $error("Command upper byte not zero."); // see R19
   chk_confirm_last: assert property (@(posedge clk) disable iff (rst)
      phase_reg == P_CONFIRM && flash_dq_oe |-> flash_dq_out == 16'h00D0)
      else $error("Confirm not D0."); // see R09
   chk_wake_wait: assert property (@(posedge clk) disable iff (rst)
      state_reg == S_WAKE |-> flash_ctl.chip_select0_n)
      else $error("Access during wake time."); // see R01
   chk_pd_low: assert property (@(posedge clk) disable iff (rst)
      state_reg == S_PD |-> flash_ctl.chip_select0_n &&
      !flash_ctl.powerdown_reset_n)
      else $error("Power-down pin wrong."); // see R24
   cov_write: cover property (@(posedge clk) $rose(flash_ctl.write_enable_n));
   cov_read: cover property (@(posedge clk) state_reg == S_RWAIT);
   cov_buf: cover property (@(posedge clk) phase_reg == P_CONFIRM);
   cov_pd: cover property (@(posedge clk) state_reg == S_PD);
endmodule // fci_host

// ==== testbench/fci_flash_model.sv ====
`timescale 1ns/1ps
module fci_flash_model
   import fci_pkg::*;
#(
   parameter logic [15:0] ID_CODE = 16'h1234, // Arbitrary value.
   parameter int BUSY_NS = 2000,
   parameter int BLK_LSB = 15
)(
   input wire logic [ADDR_W-1:0] addr,
   input wire fci_ctl_t ctl,
   input wire logic [DATA_W-1:0] dq_drv,
   input wire logic dq_oe,
   output logic [DATA_W-1:0] dq,
   output logic sts
);
   logic [7:0] mode = 8'hFF;
   logic [7:0] pend = 8'h00;
   logic [7:0] c;
   logic busy = 1'b0;
   logic fail = 1'b0;
   logic [DATA_W-1:0] last = 16'h0000;
   logic [DATA_W-1:0] rd_val;
   logic [7:0] log_q[$];
   logic [DATA_W-1:0] bdat[$];
   int left = 0;
   logic [(1 << (ADDR_W - BLK_LSB))-1:0] lk = '0;
   wire free_blk = !(lk[addr[ADDR_W-1:BLK_LSB]] && !ctl.write_protect_n);
   wire wstb = ctl.write_enable_n | ctl.chip_select0_n | ctl.chip_select1_n;
   wire drive = !(ctl.chip_select0_n | ctl.chip_select1_n |
      ctl.output_enable_n) && ctl.powerdown_reset_n;
   assign sts = !busy;
   always_comb begin
      case (mode)
         CMD_READ_ID: rd_val = ID_CODE + 16'(addr[7:0]);
         CMD_READ_QUERY: rd_val = {8'h00, addr[7:0] ^ 8'h51};
         CMD_BUF_WRITE: rd_val = 16'h0080; // Buffer always free.
         CMD_READ_STATUS: rd_val = {8'h00, !busy, 2'h0, fail, 4'h0};
         default: rd_val = addr[15:0] ^ 16'h5A5A;
      endcase
   end
   // A released bus shows the complement, so a stale value never passes.
   assign dq = dq_oe ? dq_drv : (drive ? rd_val : ~last);
   always @(dq) if (dq_oe || drive) last = dq;
   task automatic start_op(input logic ok);
      if (!ok) fail = 1'b1;
      else begin
         busy = 1'b1;
         busy <= #(BUSY_NS) 1'b0;
      end
   endtask
   always @(negedge ctl.powerdown_reset_n) begin
      mode = CMD_READ_ARRAY;
      pend = 8'h00;
      left = 0;
      busy = 1'b0;
      fail = 1'b0;
   end
   always @(posedge wstb) begin
      c = dq_drv[7:0];
      if (ctl.powerdown_reset_n && ctl.output_enable_n) begin
         log_q.push_back(c);
         if (left > 0) begin
            bdat.push_back(dq_drv);
            left = left - 1;
            if (left == 0) pend = 8'hE9;
         end else if (pend == CMD_BUF_WRITE) begin
            left = int'(c) + 1;
         end else if (pend != 8'h00) begin
            mode = CMD_READ_STATUS;
            if (pend == 8'hE9 || pend == CMD_CHIP_ERASE)
               start_op(c == CMD_CONFIRM);
            else if (pend == CMD_BLOCK_ERASE)
               start_op(c == CMD_CONFIRM && free_blk);
            else if (pend == CMD_LOCK_SETUP) begin
               start_op(ctl.write_protect_n &&
                  (c == CMD_LOCK_SET || c == CMD_CONFIRM));
               if (ctl.write_protect_n && c == CMD_LOCK_SET)
                  lk[addr[ADDR_W-1:BLK_LSB]] = 1'b1;
               if (ctl.write_protect_n && c == CMD_CONFIRM) lk = '0;
            end else if (pend == CMD_PIN_CONFIG) start_op(1'b1);
            else start_op(free_blk);
            pend = 8'h00;
         end else if (c == CMD_READ_ARRAY) begin
            if (!busy) mode = c;
         end else if (c == CMD_CLEAR_STATUS) fail = 1'b0;
         else if (c == CMD_SUSPEND) busy = 1'b0;
         else if (c == CMD_READ_ID || c == CMD_READ_QUERY ||
            c == CMD_READ_STATUS) mode = c;
         else if (c != CMD_CONFIRM) begin
            pend = c;
            if (c == CMD_BUF_WRITE) mode = c;
         end
      end
   end
endmodule // fci_flash_model

// ==== testbench/fci_host_tb.sv ====
`timescale 1ns/1ps
module fci_host_tb
   import fci_pkg::*;
;
   localparam logic [15:0] ID_VAL = 16'h1234; // Arbitrary value.
   logic clk, rst, reg_write, reg_read, flash_dq_oe, sts;
   logic [3:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, rv;
   logic [ADDR_W-1:0] flash_addr, a;
   fci_ctl_t flash_ctl;
   logic [DATA_W-1:0] flash_dq_in, flash_dq_out;
   logic [7:0] c1[7] = '{8'h20, 8'h30, 8'h60, 8'h60, 8'hB8, 8'h40, 8'h10};
   logic [7:0] c2[7] = '{8'hD0, 8'hD0, 8'h01, 8'hD0, 8'h01, 8'h5A, 8'hA5};
   logic [7:0] s1[5] = '{8'hFF, 8'h50, 8'hB0, 8'hD0, 8'h98};
   logic [15:0] w[$];
   int failures = 0;
   int comparisons = 0;
   int seed = 32'h5f91;
   int n;
   fci_host dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .flash_addr(flash_addr), .flash_ctl(flash_ctl),
      .flash_dq_in(flash_dq_in), .flash_dq_out(flash_dq_out),
      .flash_dq_oe(flash_dq_oe), .status_output_pin(sts));
   fci_flash_model #(.ID_CODE(ID_VAL)) fm (.addr(flash_addr), .ctl(flash_ctl),
      .dq_drv(flash_dq_out), .dq_oe(flash_dq_oe), .dq(flash_dq_in), .sts(sts));
   task automatic check(input string what, input logic [31:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [3:0] ad, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= ad;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] ad, output logic [31:0] d);
      @(posedge clk);
      reg_addr <= ad;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      @(negedge clk);
      d = reg_rdata;
   endtask
   task automatic wait_clear(input int b);
      for (int i = 0; i < 400; i++) begin
         rd(REG_STATUS, rv);
         if (rv[b] === 1'b0) return;
      end
      failures++;
      report_and_stop();
   endtask
   function automatic logic [31:0] mk(input logic r, t, b,
      input logic [3:0] n, input logic [7:0] d2, d1);
      return {1'b1, r, t, b, 8'h00, n, d2, d1};
   endfunction
   task automatic cmd(input logic [31:0] c);
      wr(REG_ADDR, 32'(a));
      wr(REG_CTRL, c);
      wait_clear(0);
   endtask
   task automatic rdcmd(input logic [7:0] code, input logic [15:0] exp);
      cmd(mk(1'b1, 1'b1, 1'b0, 4'h0, 8'h00, code));
      rd(REG_DATA, rv);
      check("read data", rv, 32'(exp));
   endtask
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      rst = 1'b1;
      reg_write = 1'b0;
      reg_read = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 32'h0;
      a = 22'h0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      wait_clear(1);
      check("mode", 32'(fm.mode), 32'hFF);
      rd(4'hF, rv);
      check("unmapped", rv, 32'h0);
      wr(REG_PINS, 32'h3);
      repeat (2) @(posedge clk);
      check("pins", {30'h0, flash_ctl.byte_wide, flash_ctl.write_protect_n},
         32'h3);
      rdcmd(CMD_READ_STATUS, 16'h0080);
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         a = ADDR_W'($random(seed));
         rdcmd(CMD_READ_ARRAY, a[15:0] ^ 16'h5A5A);
         rdcmd(CMD_READ_ID, ID_VAL + 16'(a[7:0]));
         rdcmd(CMD_READ_QUERY, {8'h00, a[7:0] ^ 8'h51});
      end
      wr(REG_PINS, 32'h1);
      rdcmd(CMD_READ_ARRAY, {8'h00, a[7:0] ^ 8'h5A});
      wr(REG_PINS, 32'h3);
      $display("test read modes done");
      // A wrong second code must leave the engine idle and flag a failure.
      cmd(mk(1'b0, 1'b1, 1'b0, 4'h0, 8'hFF, CMD_BLOCK_ERASE));
      rdcmd(CMD_READ_STATUS, 16'h0090);
      cmd(mk(1'b0, 1'b0, 1'b0, 4'h0, 8'h00, CMD_CLEAR_STATUS));
      rdcmd(CMD_READ_STATUS, 16'h0080);
      wr(REG_PINS, 32'h2);
      cmd(mk(1'b0, 1'b1, 1'b0, 4'h0, CMD_LOCK_SET, CMD_LOCK_SETUP));
      rdcmd(CMD_READ_STATUS, 16'h0090);
      wr(REG_PINS, 32'h3);
      cmd(mk(1'b0, 1'b0, 1'b0, 4'h0, 8'h00, CMD_CLEAR_STATUS));
      wr(REG_CTRL, mk(1'b0, 1'b0, 1'b0, 4'h0, 8'h00, 8'h77));
      rd(REG_STATUS, rv);
      check("reserved code", 32'(rv[0]), 32'h0);
      $display("test refusals done");
      for (int i = 0; i < 7; i++) begin
         cmd(mk(1'b0, 1'b1, 1'b0, 4'h0, c2[i], c1[i]));
         check("code one", 32'(fm.log_q[fm.log_q.size()-2]), 32'(c1[i]));
         check("code two", 32'(fm.log_q[$]), 32'(c2[i]));
         rd(REG_STATUS, rv);
         check("busy pin", 32'(rv[3]), 32'h0);
         if (i == 0) rdcmd(CMD_READ_ARRAY, 16'h0000);
         repeat (120) @(posedge clk);
      end
      // A locked block must refuse an erase once write protect is low.
      cmd(mk(1'b0, 1'b1, 1'b0, 4'h0, CMD_LOCK_SET, CMD_LOCK_SETUP));
      repeat (120) @(posedge clk);
      wr(REG_PINS, 32'h2);
      cmd(mk(1'b0, 1'b1, 1'b0, 4'h0, CMD_CONFIRM, CMD_BLOCK_ERASE));
      rdcmd(CMD_READ_STATUS, 16'h0090);
      wr(REG_PINS, 32'h3);
      cmd(mk(1'b0, 1'b1, 1'b0, 4'h0, CMD_CONFIRM, CMD_LOCK_SETUP));
      repeat (120) @(posedge clk);
      cmd(mk(1'b0, 1'b0, 1'b0, 4'h0, 8'h00, CMD_CLEAR_STATUS));
      rdcmd(CMD_READ_ARRAY, a[15:0] ^ 16'h5A5A);
      for (int i = 0; i < 5; i++) begin
         cmd(mk(1'b0, 1'b0, 1'b0, 4'h0, 8'h00, s1[i]));
         check("single", 32'(fm.log_q[$]), 32'(s1[i]));
      end
      wr(REG_PINS, 32'h7);
      repeat (10) @(posedge clk);
      wr(REG_PINS, 32'h3);
      repeat (2) @(posedge clk);
      wait_clear(1);
      check("wake mode", 32'(fm.mode), 32'hFF);
      rdcmd(CMD_READ_STATUS, 16'h0080);
      $display("test command set done");
      for (int k = 0; k < 3; k++) begin
         n = (k == 0) ? 0 : (k == 1) ? 15 : {$random(seed)} % 16;
         w.delete();
         fm.bdat.delete();
         for (int j = 0; j <= n; j++) begin
            w.push_back(16'($random(seed)));
            wr(REG_BUF, 32'(w[j]));
         end
         cmd(mk(1'b0, 1'b0, 1'b1, 4'(n), 8'h00, CMD_BUF_WRITE));
         check("count", 32'(fm.bdat.size()), 32'(n + 1));
         for (int j = 0; j <= n; j++) begin
            check("word", 32'(fm.bdat[j]), 32'(w[j]));
         end
         check("confirm", 32'(fm.log_q[$]), 32'(CMD_CONFIRM));
         rd(REG_DATA, rv);
         check("buffer free", rv, 32'h0080);
         repeat (120) @(posedge clk);
      end
      $display("test buffered write done");
      report_and_stop();
   end
endmodule // fci_host_tb
